// file: asu_cfg.svh
// offsets, field positions, reset values and codes of the sample unpacker
`ifndef ASU_CFG_SVH
`define ASU_CFG_SVH

// register numbers
`define ASU_REG_CONV_MODE 32'h000312B8
`define ASU_REG_CONV_AVAIL 32'h000312B9
`define ASU_REG_OUTBUF_SIZE 32'h000000D1

// conversion mode codes
`define ASU_CONV_PASSTHROUGH 32'h00000000
`define ASU_CONV_SHIFT_BY_FOUR 32'h00000004
`define ASU_CONV_SHIFT_BY_TWO 32'h00000008
`define ASU_CONV_SHIFT_BY_ONE 32'h00000010
`define ASU_CONV_AVAIL_MASK 32'h0000001C
`define ASU_CONV_MODE_RESET 32'h00000000

// hardware output buffer size, bytes
`define ASU_OUTBUF_MIN 64'h0000000000000400
`define ASU_OUTBUF_INSTALLED 64'h0000000100000000

// sample layout
`define ASU_NUM_CH 4
`define ASU_SAMPLE_W 16
`define ASU_DIG_MAX 3
`define ASU_FIFO_DEPTH 8

`endif

// file: asu_pkg.sv
// types shared by the sample unpacker modules
package asu_pkg;

  // gray-coded along idle -> gather -> present -> gather
  typedef enum logic [1:0] {
    ASU_ST_IDLE = 2'b00,
    ASU_ST_GATHER = 2'b01,
    ASU_ST_PRESENT = 2'b11
  } asu_state_t;

  typedef logic [15:0] asu_sample_t;
  typedef logic [2:0] asu_dig_t;

endpackage

// file: asu_fifo_if.sv
// valid/ready carrier between the unpacker and its input fifo
`timescale 1ns/100ps
interface asu_fifo_if #(
  parameter int WIDTH = 16
);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport fifo (input wr_valid, input wr_data, input rd_ready,
                output wr_ready, output rd_valid, output rd_data);
  modport user (output wr_valid, output wr_data, output rd_ready,
                input wr_ready, input rd_valid, input rd_data);
endinterface

// file: asu_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module asu_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // both sides
  asu_fifo_if.fifo f
);
  import asu_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } asu_fifo_st_t;

  asu_fifo_st_t st_reg;
  asu_fifo_st_t st_next;
  logic push;
  logic pop;

  assign f.wr_ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign f.rd_valid = (st_reg.cnt != '0);
  assign f.rd_data = st_reg.mem[st_reg.rd];
  assign push = f.wr_valid && f.wr_ready;
  assign pop = f.rd_valid && f.rd_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = f.wr_data;
      st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// file: asu_unpack.sv
// sample unpacker: demultiplex, hardware conversion and embedded digital split
//
// Overview of operation
// RQ1: words arrive channel-interleaved; one sample per active channel per group.
// RQ2: with two channels, first word to lower channel, second to higher.
// RQ3: with four channels, words go to channels 0, 1, 2, 3, repeating.
// RQ4: analog samples are two's-complement signed 16-bit, -32768 to +32767.
// RQ5: one digital bit: D15 to digital line, D14..D0 analog.
// RQ6: two digital bits: D15, D14 to digital lines, D13..D0 analog.
// RQ7: three digital bits: D15..D13 to digital lines, D12..D0 analog.
// RQ8: analog remainder shifted up to DAC msb, staying two's-complement.
// RQ9: mode code zero passes 16-bit words unchanged.
// RQ10: mode 4h shifts every sample left by four.
// RQ11: mode 8h shifts every sample left by two.
// RQ12: mode 10h shifts every sample left by one.
// RQ13: one global writable conversion mode; reading returns current mode.
// RQ14: conversion shifts whole word, digital bits included, any channel.
// RQ15: read-only bitmask shows every supported conversion mode code.
// RQ16: host should not make the output buffer needlessly small.
// RQ17: output buffer size only powers of two from 1k to installed memory.
// RQ18: upward shifts fill vacated low bits with zeros.
// RQ19: split and conversion applied to the whole group in one cycle.
`timescale 1ns/100ps
`include "asu_cfg.svh"
module asu_unpack #(
  parameter int NUM_CH = `ASU_NUM_CH,
  parameter int FIFO_DEPTH = `ASU_FIFO_DEPTH,
  parameter logic [63:0] OUTBUF_INSTALLED = `ASU_OUTBUF_INSTALLED
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // channel setup
  input wire logic [NUM_CH-1:0] chan_enable,
  input wire logic [1:0] embed_bits,
  // multiplexed sample words from the transfer buffer
  input wire logic in_valid,
  input wire asu_pkg::asu_sample_t in_word,
  output logic in_ready,
  // per-channel group towards the dacs
  output logic dac_valid,
  input wire logic dac_ready,
  output asu_pkg::asu_sample_t [NUM_CH-1:0] channel_dac_value,
  output asu_pkg::asu_dig_t [NUM_CH-1:0] dig_out,
  // register access
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [31:0] reg_num,
  input wire logic [63:0] reg_wdata,
  output logic [63:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  // current hardware output buffer size, bytes
  output logic [63:0] hw_output_buffer_size
);
  import asu_pkg::*;

  localparam int SW = `ASU_SAMPLE_W;
  localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

  typedef struct packed {
    asu_state_t state;
    logic [NUM_CH-1:0] mask;
    logic [CW-1:0] slot;
    logic [NUM_CH-1:0][SW-1:0] gather;
    logic [31:0] conv_mode;
    logic [63:0] buf_size;
    logic out_valid;
    logic [NUM_CH-1:0][SW-1:0] dac;
    logic [NUM_CH-1:0][2:0] dig;
    logic [63:0] rdata;
    logic ack;
    logic err;
  } asu_unpack_st_t;

  asu_unpack_st_t st_reg;
  asu_unpack_st_t st_next;

  asu_fifo_if #(.WIDTH(SW)) fin ();

  asu_fifo #(
    .WIDTH(SW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .f(fin.fifo)
  );

  // position of the k-th active channel in the mask
  function automatic logic [CW-1:0] nth_chan(input logic [NUM_CH-1:0] m,
                                             input logic [CW-1:0] k);
    logic [CW-1:0] res;
    logic [CW:0] seen;
    res = '0;
    seen = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (m[i]) begin
        if (seen == {1'b0, k}) begin
          res = CW'(i);
        end
        seen = seen + 1'b1;
      end
    end
    return res;
  endfunction

  function automatic logic [CW:0] count_ones(input logic [NUM_CH-1:0] m);
    logic [CW:0] n;
    n = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      n = n + (CW+1)'(m[i]);
    end
    return n;
  endfunction

  // valid buffer size: power of two, at least 1k, at most installed memory
  function automatic logic size_ok(input logic [63:0] v);
    return (v != '0) && ((v & (v - 64'h1)) == '0) && // RQ17
           (v >= `ASU_OUTBUF_MIN) && (v <= OUTBUF_INSTALLED); // RQ17
  endfunction

  function automatic logic mode_ok(input logic [31:0] v);
    return (v == `ASU_CONV_PASSTHROUGH) || (v == `ASU_CONV_SHIFT_BY_FOUR) ||
           (v == `ASU_CONV_SHIFT_BY_TWO) || (v == `ASU_CONV_SHIFT_BY_ONE);
  endfunction

  logic pop;
  logic [NUM_CH-1:0] grp_mask;
  logic [CW-1:0] cur_chan;
  logic last_slot;
  logic [CW:0] n_active;
  logic [NUM_CH-1:0][SW-1:0] grp_word;
  logic [NUM_CH-1:0][SW-1:0] conv_word;
  logic [NUM_CH-1:0][SW-1:0] ana_word;
  logic [NUM_CH-1:0][2:0] dig_word;

  // mask stays live until the first word of a group is taken, then it is frozen
  assign grp_mask = (st_reg.slot == '0) ? chan_enable : st_reg.mask;
  assign n_active = count_ones(grp_mask);
  assign cur_chan = nth_chan(grp_mask, st_reg.slot); // RQ1 RQ2 RQ3
  assign last_slot = ({1'b0, st_reg.slot} == n_active - 1'b1);
  assign fin.rd_ready = (st_reg.state == ASU_ST_GATHER) && (grp_mask != '0);
  assign pop = fin.rd_valid && fin.rd_ready;
  assign fin.wr_valid = in_valid;
  assign fin.wr_data = in_word;
  assign in_ready = fin.wr_ready;

  // every channel of the group is converted and split side by side
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      assign grp_word[ch] = (pop && cur_chan == CW'(ch)) ? fin.rd_data :
                            st_reg.gather[ch];

      always_comb begin
        conv_word[ch] = grp_word[ch]; // RQ9
        case (st_reg.conv_mode)
          `ASU_CONV_SHIFT_BY_FOUR: conv_word[ch] = {grp_word[ch][11:0], 4'h0}; // RQ10 RQ18
          `ASU_CONV_SHIFT_BY_TWO: conv_word[ch] = {grp_word[ch][13:0], 2'h0}; // RQ11 RQ18
          `ASU_CONV_SHIFT_BY_ONE: conv_word[ch] = {grp_word[ch][14:0], 1'h0}; // RQ12 RQ18
          default: conv_word[ch] = grp_word[ch];
        endcase
      end

      // conversion sees digital bits as ordinary data
      always_comb begin
        ana_word[ch] = conv_word[ch]; // RQ14 RQ4
        dig_word[ch] = 3'h0;
        case (embed_bits)
          2'h1: begin
            dig_word[ch] = {conv_word[ch][15], 2'h0}; // RQ5
            ana_word[ch] = {conv_word[ch][14:0], 1'h0}; // RQ5 RQ8 RQ18
          end
          2'h2: begin
            dig_word[ch] = {conv_word[ch][15:14], 1'h0}; // RQ6
            ana_word[ch] = {conv_word[ch][13:0], 2'h0}; // RQ6 RQ8 RQ18
          end
          2'h3: begin
            dig_word[ch] = conv_word[ch][15:13]; // RQ7
            ana_word[ch] = {conv_word[ch][12:0], 3'h0}; // RQ7 RQ8 RQ18
          end
          default: begin
            dig_word[ch] = 3'h0;
            ana_word[ch] = conv_word[ch];
          end
        endcase
      end
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;

    // register port; writes and reads answer one cycle later
    if (reg_wr_en) begin
      st_next.ack = 1'b1;
      if (reg_num == `ASU_REG_CONV_MODE) begin
        if (mode_ok(reg_wdata[31:0])) begin
          st_next.conv_mode = reg_wdata[31:0]; // RQ13
        end else begin
          st_next.err = 1'b1;
        end
      end else if (reg_num == `ASU_REG_OUTBUF_SIZE) begin
        if (size_ok(reg_wdata)) begin
          st_next.buf_size = reg_wdata; // RQ17
        end else begin
          st_next.err = 1'b1;
        end
      end else begin
        // the availability mask is read only
        st_next.err = 1'b1;
      end
    end else if (reg_rd_en) begin
      st_next.ack = 1'b1;
      st_next.rdata = '0;
      if (reg_num == `ASU_REG_CONV_MODE) begin
        st_next.rdata = {32'h0, st_reg.conv_mode}; // RQ13
      end else if (reg_num == `ASU_REG_CONV_AVAIL) begin
        st_next.rdata = {32'h0, `ASU_CONV_AVAIL_MASK}; // RQ15
      end else if (reg_num == `ASU_REG_OUTBUF_SIZE) begin
        st_next.rdata = st_reg.buf_size;
      end else begin
        st_next.err = 1'b1;
      end
    end

    case (st_reg.state)
      ASU_ST_IDLE: begin
        // mask is frozen per group so a change never splits one
        if (chan_enable != '0) begin
          st_next.mask = chan_enable;
          st_next.slot = '0;
          st_next.state = ASU_ST_GATHER;
        end
      end
      ASU_ST_GATHER: begin
        if (pop) begin
          st_next.gather[cur_chan] = fin.rd_data; // RQ1
          st_next.mask = grp_mask;
          if (last_slot) begin
            for (int i = 0; i < NUM_CH; i++) begin
              // inactive channels rest at mid-scale zero
              st_next.dac[i] = grp_mask[i] ? ana_word[i] : '0; // RQ19
              st_next.dig[i] = grp_mask[i] ? dig_word[i] : 3'h0; // RQ19
            end
            st_next.out_valid = 1'b1;
            st_next.state = ASU_ST_PRESENT;
          end else begin
            st_next.slot = st_reg.slot + 1'b1; // RQ1
          end
        end
      end
      ASU_ST_PRESENT: begin
        if (dac_ready) begin
          st_next.out_valid = 1'b0;
          st_next.slot = '0;
          st_next.mask = chan_enable;
          st_next.state = (chan_enable != '0) ? ASU_ST_GATHER : ASU_ST_IDLE;
        end
      end
      default: begin
        st_next.state = ASU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.state <= ASU_ST_IDLE;
      st_reg.conv_mode <= `ASU_CONV_MODE_RESET;
      st_reg.buf_size <= OUTBUF_INSTALLED;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dac_valid = st_reg.out_valid;
  assign channel_dac_value = st_reg.dac;
  assign dig_out = st_reg.dig;
  assign reg_rdata = st_reg.rdata;
  assign reg_ack = st_reg.ack;
  assign reg_err = st_reg.err;
  assign hw_output_buffer_size = st_reg.buf_size;
endmodule

// file: asu_unpack_sva.sv
// concurrent checks on the sample unpacker ports
`timescale 1ns/100ps
`include "asu_cfg.svh"
module asu_unpack_sva #(
  parameter int NUM_CH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // stream
  input wire logic in_ready,
  input wire logic dac_valid,
  input wire logic dac_ready,
  input wire asu_pkg::asu_sample_t [NUM_CH-1:0] channel_dac_value,
  input wire asu_pkg::asu_dig_t [NUM_CH-1:0] dig_out,
  // registers
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [31:0] reg_num,
  input wire logic [63:0] reg_wdata,
  input wire logic [63:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic [63:0] hw_output_buffer_size
);
  import asu_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_wr_mode;
    reg_wr_en && reg_num == `ASU_REG_CONV_MODE && reg_wdata inside {0, 4, 8, 16};
  endsequence
  sequence s_rd_mode;
    reg_rd_en && !reg_wr_en && reg_num == `ASU_REG_CONV_MODE;
  endsequence
  a_ack_follows: assert property ((reg_wr_en || reg_rd_en) |=> reg_ack)
    else $error("no ack after strobe");
  a_ack_pulse: assert property (!(reg_wr_en || reg_rd_en) |=> !reg_ack && !reg_err)
    else $error("ack or err without strobe");
  a_avail_mask: assert property (reg_rd_en && !reg_wr_en && reg_num == `ASU_REG_CONV_AVAIL
    |=> reg_rdata == 64'h1C && !reg_err) else $error("mode mask wrong");
  a_bad_mode: assert property (reg_wr_en && reg_num == `ASU_REG_CONV_MODE
    && !(reg_wdata inside {0, 4, 8, 16}) |=> reg_err) else $error("bad mode accepted");
  a_mode_readback: assert property (s_wr_mode ##1 !reg_wr_en ##1 s_rd_mode
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("mode readback wrong");
  a_group_holds: assert property (dac_valid && !dac_ready |=> dac_valid
    && $stable(channel_dac_value) && $stable(dig_out)) else $error("group not held");
  a_handoff_clears: assert property (dac_valid && dac_ready |=> !dac_valid)
    else $error("group repeated");
  a_buf_pow2: assert property (hw_output_buffer_size >= `ASU_OUTBUF_MIN
    && (hw_output_buffer_size & (hw_output_buffer_size - 64'h1)) == 64'h0)
    else $error("buffer size illegal");
  a_reset_idle: assert property (disable iff (1'b0) rst |=> !dac_valid && in_ready && !reg_ack)
    else $error("not idle after reset");
endmodule
bind asu_unpack asu_unpack_sva #(.NUM_CH(NUM_CH)) u_asu_unpack_sva (.ref_clk, .rst,
  .in_ready, .dac_valid, .dac_ready, .channel_dac_value, .dig_out, .reg_wr_en,
  .reg_rd_en, .reg_num, .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .hw_output_buffer_size);

// file: asu_dac_sink.sv
// dac-side consumer taking groups at once or with stalls
`timescale 1ns/100ps
module asu_dac_sink (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pace and handshake
  input wire logic slow,
  output logic dac_ready
);
  logic [2:0] cnt_reg;
  always_ff @(posedge ref_clk) begin
    cnt_reg <= rst ? 3'h0 : cnt_reg + 3'h1;
  end
  // slow pace stalls seven cycles in eight so the fifo backs up
  assign dac_ready = !slow || cnt_reg == 3'h7;
endmodule

// file: asu_unpack_test.sv
// self-checking bench for the sample unpacker
`timescale 1ns/100ps
`include "asu_cfg.svh"
module asu_unpack_test;
  import asu_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] chan_enable = 4'h0;
  logic [1:0] embed_bits = 2'h0;
  logic in_valid = 1'b0;
  asu_sample_t in_word = 16'h0;
  logic in_ready, dac_valid, dac_ready, reg_ack, reg_err;
  logic slow = 1'b0;
  logic saw_full = 1'b0;
  asu_sample_t [3:0] channel_dac_value;
  asu_dig_t [3:0] dig_out;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [31:0] reg_num = 32'h0;
  logic [63:0] reg_wdata = 64'h0;
  logic [63:0] reg_rdata, hw_output_buffer_size;
  logic [31:0] seed = 32'hEE5D;
  logic [31:0] cur_mode = 32'h0;
  logic [31:0] modes[4] = '{32'h0, 32'h4, 32'h8, 32'h10};
  logic [3:0] masks[6] = '{4'h1, 4'h3, 4'h5, 4'hF, 4'hA, 4'hC};
  asu_sample_t words[$];
  int num_errors = 0;
  int num_checks = 0;
  always #2 ref_clk = ~ref_clk;
  asu_unpack u_asu_unpack (.ref_clk, .rst, .chan_enable, .embed_bits, .in_valid, .in_word,
    .in_ready, .dac_valid, .dac_ready, .channel_dac_value, .dig_out, .reg_wr_en, .reg_rd_en,
    .reg_num, .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .hw_output_buffer_size);
  asu_dac_sink u_asu_dac_sink (.ref_clk, .rst, .slow, .dac_ready);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // whole word shifted first, so embedded bits move too
  function automatic logic [18:0] expect_chan(input asu_sample_t w, input logic [1:0] e);
    logic [15:0] x;
    x = w << (cur_mode == 32'h4 ? 4 : cur_mode == 32'h8 ? 2 : cur_mode == 32'h10 ? 1 : 0);
    return {x[15:13] & ~(3'h7 >> e), x << e};
  endfunction
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic reg_op(input logic wr, input logic [31:0] num, input logic [63:0] wd,
                        input logic err, input logic [63:0] rd);
    @(posedge ref_clk);
    reg_wr_en <= wr;
    reg_rd_en <= !wr;
    reg_num <= num;
    reg_wdata <= wd;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    @(negedge ref_clk);
    chk("reg_ack", 64'h1, {63'h0, reg_ack});
    chk("reg_err", {63'h0, err}, {63'h0, reg_err});
    if (!wr) chk("reg_rdata", rd, reg_rdata);
  endtask
  task automatic push(input asu_sample_t w);
    int n;
    logic ok;
    n = 0;
    in_valid <= 1'b1;
    in_word <= w;
    words.push_back(w);
    do begin
      @(negedge ref_clk);
      ok = in_ready;
      saw_full |= (ok === 1'b0);
      @(posedge ref_clk);
      n++;
    end while (ok !== 1'b1 && n < 400);
    if (ok !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask
  task automatic collect(input logic [3:0] m, input logic [1:0] e);
    int n;
    logic [18:0] x;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!(dac_valid === 1'b1 && dac_ready === 1'b1) && n < 400);
    if (!(dac_valid === 1'b1 && dac_ready === 1'b1)) begin
      num_errors++;
      results();
    end
    for (int c = 0; c < 4; c++) begin
      x = m[c] ? expect_chan(words.pop_front(), e) : 19'h0;
      chk("channel_dac_value", {48'h0, x[15:0]}, {48'h0, channel_dac_value[c]});
      chk("dig_out", {61'h0, x[18:16]}, {61'h0, dig_out[c]});
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    reg_op(1'b0, `ASU_REG_CONV_AVAIL, 64'h0, 1'b0, 64'h1C);
    reg_op(1'b1, `ASU_REG_CONV_AVAIL, 64'h4, 1'b1, 64'h0);
    reg_op(1'b1, `ASU_REG_CONV_MODE, 64'h3, 1'b1, 64'h0);
    reg_op(1'b0, `ASU_REG_CONV_MODE, 64'h0, 1'b0, 64'h0);
    reg_op(1'b0, 32'h00000123, 64'h0, 1'b1, 64'h0);
    reg_op(1'b0, `ASU_REG_OUTBUF_SIZE, 64'h0, 1'b0, `ASU_OUTBUF_INSTALLED);
    reg_op(1'b1, `ASU_REG_OUTBUF_SIZE, 64'h600, 1'b1, 64'h0);
    reg_op(1'b1, `ASU_REG_OUTBUF_SIZE, 64'h200, 1'b1, 64'h0);
    reg_op(1'b1, `ASU_REG_OUTBUF_SIZE, 64'h400, 1'b0, 64'h0);
    reg_op(1'b0, `ASU_REG_OUTBUF_SIZE, 64'h0, 1'b0, 64'h400);
    reg_op(1'b1, `ASU_REG_OUTBUF_SIZE, `ASU_OUTBUF_INSTALLED, 1'b0, 64'h0);
    for (int i = 0; i < 8; i++) begin
      cur_mode = modes[i % 4];
      reg_op(1'b1, `ASU_REG_CONV_MODE, {32'h0, cur_mode}, 1'b0, 64'h0);
      reg_op(1'b0, `ASU_REG_CONV_MODE, 64'h0, 1'b0, {32'h0, cur_mode});
      @(posedge ref_clk);
      chan_enable <= masks[i % 6];
      embed_bits <= 2'(i / 2);
      slow <= i[0];
      fork
        begin
          for (int g = 0; g < 6 * $countones(masks[i % 6]); g++) begin
            seed = lfsr(seed);
            push(g == 0 ? 16'h8000 : g == 1 ? 16'h7FFF : seed[15:0]);
          end
          in_valid <= 1'b0;
        end
        repeat (6) collect(masks[i % 6], 2'(i / 2));
      join
    end
    chk("fifo back-pressure", 64'h1, {63'h0, saw_full});
    results();
  end
endmodule
